// >>> hdl/dppc_params.svh
// Constants for the downstream port power control block.
// Assumes a 40 MHz core clock and a 32-bit AHB-Lite register bus.
`ifndef DPPC_PARAMS_SVH
`define DPPC_PARAMS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define DPPC_CFG_OFFSET 8'h00
`define DPPC_STATUS_OFFSET 8'h04
`define DPPC_IRQ_STAT_OFFSET 8'h08
`define DPPC_IRQ_MASK_OFFSET 8'h0C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define DPPC_CFG_DISABLE_LSB 0
`define DPPC_CFG_SPLIT_BIT 3
`define DPPC_CFG_SS_EN_BIT 4
`define DPPC_STAT_ENABLED_LSB 0
`define DPPC_STAT_OC_LSB 3
`define DPPC_STAT_SPLIT_BIT 6
`define DPPC_STAT_SS_BIT 7

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define DPPC_CFG_DISABLE_RESET 3'h7
`define DPPC_IRQ_MASK_RESET 3'h0
`define DPPC_CLK_MHZ 40
`define DPPC_OC_BLANK_NS 1000
`define DPPC_OC_BLANK_CYCLES ((`DPPC_OC_BLANK_NS * `DPPC_CLK_MHZ + 999) / 1000)

`endif

// >>> hdl/dppc_pkg.sv
// Types shared by the downstream port power control modules.
// Assumes nothing of its surroundings.
package dppc_pkg;

   // ------------------------------------------------------------
   // Port index: bit 0 is port 3, bit 1 port 4, bit 2 port 5
   // ------------------------------------------------------------
   typedef logic [2:0] port_vec_type;

   typedef struct packed {
      logic [2:0] stage1;
      logic [2:0] stage2;
   } sync_state_type;

   typedef enum logic [1:0] {
      PORT_OFF   = 2'h1,
      PORT_BLANK = 2'h2
   } port_mode_type;

   typedef struct packed {
      logic [5:0] blankCnt;
      logic       ocLevel;
      logic       ocEvent;
   } port_state_type;

   typedef struct packed {
      port_vec_type cfgDisable;
      logic         split;
      logic         ssEnable;
      port_vec_type irqStat;
      port_vec_type irqMask;
      logic         dataSel;
      logic         dataWrite;
      logic [7:0]   dataAddr;
      logic [31:0]  rdata;
   } top_state_type;

endpackage

// >>> hdl/dppc_sync.sv
// Two-flop synchroniser for the three power sense pin levels.
// Assumes the pins change without regard to the core clock.
`timescale 1ns/10ps
module dppc_sync (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // Levels
   input  wire logic [2:0] asyncIn,
   output logic      [2:0] syncOut
);

   dppc_pkg::sync_state_type state_q;
   dppc_pkg::sync_state_type state_d;

   // Pins idle high through the pull-up, so reset to the idle level.
   always_comb begin
      state_d        = state_q;
      state_d.stage1 = asyncIn;
      state_d.stage2 = state_q.stage1;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= '{stage1: 3'h7, stage2: 3'h7};
      end else begin
         state_q <= state_d;
      end
   end

   assign syncOut = state_q.stage2;

endmodule

// >>> hdl/dppc_port_ctl.sv
// Per-port power sense logic: blanking after enable and overcurrent detect.
// Assumes the pin level is already synchronised to mclk.
`timescale 1ns/10ps
`include "dppc_params.svh"
module dppc_port_ctl (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rstn,
   // Control and sense
   input  wire logic portEnable,
   input  wire logic pinLevel,
   // Results
   output logic      ocLevel,
   output logic      ocEvent
);

   localparam logic [5:0] BLANK = 6'(`DPPC_OC_BLANK_CYCLES);

   dppc_pkg::port_state_type state_q;
   dppc_pkg::port_state_type state_d;
   dppc_pkg::port_mode_type  mode;

   // The pull-up needs time to lift the pin after the drive-low is released;
   // without this blanking every enable would look like an overcurrent.
   always_comb begin
      state_d = state_q;
      mode    = dppc_pkg::PORT_BLANK;
      if (!portEnable) begin
         mode = dppc_pkg::PORT_OFF;
      end
      case (mode)
         dppc_pkg::PORT_OFF: begin
            state_d.blankCnt = BLANK;
            state_d.ocLevel  = 1'b0;
         end
         dppc_pkg::PORT_BLANK: begin
            if (state_q.blankCnt != 6'h00) begin
               state_d.blankCnt = state_q.blankCnt - 6'h01;
            end
            state_d.ocLevel = (state_q.blankCnt == 6'h00) && !pinLevel;
         end
         default: begin
            state_d.blankCnt = BLANK;
            state_d.ocLevel  = 1'b0;
         end
      endcase
      state_d.ocEvent = state_d.ocLevel && !state_q.ocLevel;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= '{blankCnt: 6'h00, ocLevel: 1'b0, ocEvent: 1'b0};
      end else begin
         state_q <= state_d;
      end
   end

   assign ocLevel = state_q.ocLevel;
   assign ocEvent = state_q.ocEvent;

endmodule

// >>> hdl/dppc_top.sv
// Power enable and overcurrent sense control for downstream ports 3, 4 and 5.
// Assumes an AHB-Lite master on mclk and an external power switch on each pin.
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`include "dppc_params.svh"

// How it works
// - Enabled port: pin released as input with pull-up on.
// - The pulled-up pin level asks the external switch for power.
// - Enabled port: low on the pin from the monitor means overcurrent.
// - Disabled port: pin becomes an output driven low, removing power.
// - Configuration bit or host request each disables the port.
// - Port 5 pin governs USB 2.0 and 3.2 parts together.
// - Split off: ports 3 and 4 pins govern both parts.
// - Split on: ports 3 and 4 pins govern the USB 2.0 part only.
// - Split on: separate high output enables port 4 USB 3.2 part.
module dppc_top (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // Hub core
   input  wire logic [2:0]  hostPortDisable,
   output logic      [2:0]  portUsb2Power,
   output logic      [2:0]  portUsb3Power,
   output logic      [2:0]  portOvercurrent,
   output logic             irq,
   // Port 3 power sense pin
   input  wire logic        port3PowerSensePinIn,
   output logic             port3PowerSensePinOut,
   output logic             port3PowerSensePinOe,
   output logic             port3PowerSensePinPu,
   // Port 4 power sense pin
   input  wire logic        port4PowerSensePinIn,
   output logic             port4PowerSensePinOut,
   output logic             port4PowerSensePinOe,
   output logic             port4PowerSensePinPu,
   // Port 5 power sense pin
   input  wire logic        port5PowerSensePinIn,
   output logic             port5PowerSensePinOut,
   output logic             port5PowerSensePinOe,
   output logic             port5PowerSensePinPu,
   // Port 4 superspeed enable
   output logic             port4SuperspeedPowerEnable
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   dppc_pkg::top_state_type state_q;
   dppc_pkg::top_state_type state_d;

   dppc_pkg::port_vec_type portEnable;
   dppc_pkg::port_vec_type pinRaw;
   dppc_pkg::port_vec_type pinSync;
   dppc_pkg::port_vec_type ocLevel;
   dppc_pkg::port_vec_type ocEvent;
   dppc_pkg::port_vec_type usb3Own;

   logic        addrPhase;
   logic [31:0] readValue;
   logic [31:0] statusWord;
   logic        ssOut;

   // ------------------------------------------------------------
   // Port enable
   // ------------------------------------------------------------
   // A port runs only when neither software configuration nor the host
   // has turned it off; either one alone forces the drive-low state.
   assign portEnable = ~state_q.cfgDisable & ~hostPortDisable;

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   // The output value is always low; only the enable and pull-up move. A disabled
   // port therefore pulls the switch enable low, and an enabled one
   // releases the pin to the pull-up which requests power.
   assign port3PowerSensePinOut = 1'b0;
   assign port4PowerSensePinOut = 1'b0;
   assign port5PowerSensePinOut = 1'b0;

   assign port3PowerSensePinOe = !portEnable[0];
   assign port4PowerSensePinOe = !portEnable[1];
   assign port5PowerSensePinOe = !portEnable[2];

   assign port3PowerSensePinPu = portEnable[0];
   assign port4PowerSensePinPu = portEnable[1];
   assign port5PowerSensePinPu = portEnable[2];

   // ------------------------------------------------------------
   // Overcurrent sensing
   // ------------------------------------------------------------
   assign pinRaw = {port5PowerSensePinIn, port4PowerSensePinIn, port3PowerSensePinIn};

   dppc_sync u_sync (
      .mclk    (mclk),
      .rstn    (rstn),
      .asyncIn (pinRaw),
      .syncOut (pinSync)
   );

   // A floating pin of a disabled port is harmless: its sense path is
   // ignored whenever the port is off.
   for (genvar i = 0; i < 3; i++) begin : g_port
      dppc_port_ctl u_port (
         .mclk       (mclk),
         .rstn       (rstn),
         .portEnable (portEnable[i]),
         .pinLevel   (pinSync[i]),
         .ocLevel    (ocLevel[i]),
         .ocEvent    (ocEvent[i])
      );
   end

   assign portOvercurrent = ocLevel;

   // ------------------------------------------------------------
   // Power coverage per port part
   // ------------------------------------------------------------
   // Port 5 has no split choice. Ports 3 and 4 hand their USB 3.2 part
   // to a separate enable when the split option is set; port 3's own
   // split enable belongs to other logic, so it reads low here.
   assign usb3Own[2] = 1'b1;
   assign usb3Own[1] = !state_q.split;
   assign usb3Own[0] = !state_q.split;

   assign portUsb2Power = portEnable & ~ocLevel;

   assign ssOut = state_q.split && state_q.ssEnable && portEnable[1];

   always_comb begin
      portUsb3Power    = portEnable & ~ocLevel & usb3Own;
      portUsb3Power[1] = usb3Own[1] ? portUsb3Power[1] : ssOut;
   end

   // Held low while the split option is off, so the unused pin never
   // powers an embedded superspeed device by accident.
   assign port4SuperspeedPowerEnable = ssOut;

   // ------------------------------------------------------------
   // Register read view
   // ------------------------------------------------------------
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[`DPPC_STAT_ENABLED_LSB +: 3] = portEnable;
      statusWord[`DPPC_STAT_OC_LSB +: 3]      = ocLevel;
      statusWord[`DPPC_STAT_SPLIT_BIT]        = state_q.split;
      statusWord[`DPPC_STAT_SS_BIT]           = ssOut;
   end

   // Reads are answered from the address phase so that hrdata comes from
   // a flip-flop yet the bus still sees zero wait states.
   always_comb begin
      readValue = 32'h0000_0000;
      case (haddr[7:0])
         `DPPC_CFG_OFFSET: begin
            readValue[`DPPC_CFG_DISABLE_LSB +: 3] = state_q.cfgDisable;
            readValue[`DPPC_CFG_SPLIT_BIT]        = state_q.split;
            readValue[`DPPC_CFG_SS_EN_BIT]        = state_q.ssEnable;
         end
         `DPPC_STATUS_OFFSET: begin
            readValue = statusWord;
         end
         `DPPC_IRQ_STAT_OFFSET: begin
            readValue[2:0] = state_q.irqStat;
         end
         `DPPC_IRQ_MASK_OFFSET: begin
            readValue[2:0] = state_q.irqMask;
         end
         default: begin
            readValue = 32'h0000_0000;
         end
      endcase
      if (haddr[31:8] != 24'h00_0000) begin
         readValue = 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   assign addrPhase = hsel && hready && htrans[1];

   always_comb begin
      state_d = state_q;

      // Address phase capture.
      state_d.dataSel = addrPhase;
      if (addrPhase) begin
         state_d.dataWrite = hwrite;
         state_d.dataAddr  = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
         if (!hwrite) begin
            state_d.rdata = readValue;
         end
      end

      // Data phase write.
      if (state_q.dataSel && state_q.dataWrite) begin
         case (state_q.dataAddr)
            `DPPC_CFG_OFFSET: begin
               state_d.cfgDisable = hwdata[`DPPC_CFG_DISABLE_LSB +: 3];
               state_d.split      = hwdata[`DPPC_CFG_SPLIT_BIT];
               state_d.ssEnable   = hwdata[`DPPC_CFG_SS_EN_BIT];
            end
            `DPPC_IRQ_STAT_OFFSET: begin
               state_d.irqStat = state_q.irqStat & ~hwdata[2:0];
            end
            `DPPC_IRQ_MASK_OFFSET: begin
               state_d.irqMask = hwdata[2:0];
            end
            default: begin
               state_d.irqMask = state_q.irqMask;
            end
         endcase
      end

      // A new overcurrent wins over a clear in the same cycle.
      state_d.irqStat = state_d.irqStat | ocEvent;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q.cfgDisable <= `DPPC_CFG_DISABLE_RESET;
         state_q.split      <= 1'b0;
         state_q.ssEnable   <= 1'b0;
         state_q.irqStat    <= 3'h0;
         state_q.irqMask    <= `DPPC_IRQ_MASK_RESET;
         state_q.dataSel    <= 1'b0;
         state_q.dataWrite  <= 1'b0;
         state_q.dataAddr   <= 8'h00;
         state_q.rdata      <= 32'h0000_0000;
      end else begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // Bus and interrupt outputs
   // ------------------------------------------------------------
   // The slave never stretches a transfer and never reports an error;
   // unmapped words read as zero and ignore writes.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = state_q.rdata;
   assign irq       = |(state_q.irqStat & state_q.irqMask);

endmodule

// >>> testbench/dppc_checker.sv
// Concurrent checks on the ports of the power control block.
// Assumes it is bound to the top module and sees its pins only.
`timescale 1ns/10ps
module dppc_checker (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       rstn,
   // Hub core side
   input wire logic [2:0] hostPortDisable,
   input wire logic [2:0] portUsb2Power,
   input wire logic [2:0] portUsb3Power,
   input wire logic [2:0] portOvercurrent,
   input wire logic       port4SuperspeedPowerEnable,
   // Pins
   input wire logic       port3PowerSensePinIn,
   input wire logic       port3PowerSensePinOut,
   input wire logic       port3PowerSensePinOe,
   input wire logic       port3PowerSensePinPu,
   input wire logic       port4PowerSensePinOut,
   input wire logic       port4PowerSensePinOe,
   input wire logic       port4PowerSensePinPu,
   input wire logic       port5PowerSensePinOut,
   input wire logic       port5PowerSensePinOe,
   input wire logic       port5PowerSensePinPu
);
   // ------------------------------------------------------------
   // Pin vectors
   // ------------------------------------------------------------
   logic [2:0] oeV;
   logic [2:0] puV;
   logic [2:0] outV;
   assign oeV = {port5PowerSensePinOe, port4PowerSensePinOe, port3PowerSensePinOe};
   assign puV = {port5PowerSensePinPu, port4PowerSensePinPu, port3PowerSensePinPu};
   assign outV = {port5PowerSensePinOut, port4PowerSensePinOut, port3PowerSensePinOut};
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence ocRise3;
      $rose(portOvercurrent[0]);
   endsequence
   AST_PULLUP: assert property (puV == ~oeV)
      else $error("pull-up not the inverse of drive enable");
   AST_DRIVE_LOW: assert property ((oeV & outV) == 3'h0)
      else $error("disabled pin not driven low");
   AST_HOST_OFF: assert property ((hostPortDisable & ~oeV) == 3'h0)
      else $error("host request did not disable port");
   AST_NO_POWER_OFF: assert property ((oeV & portUsb2Power) == 3'h0)
      else $error("power reported on a disabled port");
   AST_OC_CUTS: assert property ((portOvercurrent & portUsb2Power) == 3'h0)
      else $error("power reported during overcurrent");
   // The pin level that raises the flag was taken three edges before the rise is seen.
   AST_OC_FROM_PIN: assert property (ocRise3 |-> !$past(port3PowerSensePinIn, 3)
      && !port3PowerSensePinOe)
      else $error("overcurrent rose without a low pin");
   AST_PORT5_BOTH: assert property (portUsb3Power[2] == portUsb2Power[2])
      else $error("port 5 parts differ");
   AST_SS_SPLIT: assert property (port4SuperspeedPowerEnable |-> portUsb3Power[1]
      && !portUsb3Power[0] && !port4PowerSensePinOe)
      else $error("superspeed enable without split state");
   AST_USB3_UNDER_PIN: assert property ((portUsb3Power[1:0] & ~portUsb2Power[1:0]
      & ~{port4SuperspeedPowerEnable, 1'b0}) == 2'h0)
      else $error("usb3 part powered apart from its pin");
endmodule

// >>> testbench/dppc_switch_model.sv
// External power switch with an open-drain overcurrent flag on each pin.
// Assumes the bench asks for overcurrent through ocReq.
`timescale 1ns/10ps
module dppc_switch_model (
   // Device side
   input  wire logic [2:0] oe,
   input  wire logic [2:0] pu,
   // Fault requests
   input  wire logic [2:0] ocReq,
   // Resolved pin levels and switch state
   output logic      [2:0] pinLevel,
   output logic      [2:0] switchOn
);
   // Every pin is wired, so no port may float while enabled.
   // The monitor only pulls low; the pull-up gives the high level.
   assign pinLevel = ~oe & ~ocReq & pu;
   // The switch powers the port while the pin stands high.
   assign switchOn = pinLevel;
endmodule

// >>> testbench/test_downstream_port_power_control.sv
// Self-checking bench for the power control block.
// Assumes the AHB-Lite slave answers with hreadyout and OKAY.
`timescale 1ns/10ps
`include "dppc_params.svh"
module test_downstream_port_power_control;
   logic mclk, rstn, hsel, hwrite, hreadyout, hresp, irq, ss, split;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, hostPortDisable, ocReq, pinLevel, cfgDis, portUsb2Power;
   logic [2:0] portUsb3Power, portOvercurrent;
   logic port3PowerSensePinOut, port3PowerSensePinOe, port3PowerSensePinPu;
   logic port4PowerSensePinOut, port4PowerSensePinOe, port4PowerSensePinPu;
   logic port5PowerSensePinOut, port5PowerSensePinOe, port5PowerSensePinPu;
   logic port4SuperspeedPowerEnable;
   int errors, total_checks, i;
   always #12.5 mclk = ~mclk;
   dppc_top i_dut (.mclk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .hostPortDisable, .portUsb2Power,
      .portUsb3Power, .portOvercurrent, .irq, .port3PowerSensePinIn(pinLevel[0]),
      .port3PowerSensePinOut, .port3PowerSensePinOe, .port3PowerSensePinPu,
      .port4PowerSensePinIn(pinLevel[1]), .port4PowerSensePinOut, .port4PowerSensePinOe,
      .port4PowerSensePinPu, .port5PowerSensePinIn(pinLevel[2]), .port5PowerSensePinOut,
      .port5PowerSensePinOe, .port5PowerSensePinPu, .port4SuperspeedPowerEnable);
   dppc_switch_model i_sw (.oe({port5PowerSensePinOe, port4PowerSensePinOe,
      port3PowerSensePinOe}), .pu({port5PowerSensePinPu, port4PowerSensePinPu,
      port3PowerSensePinPu}), .ocReq, .pinLevel, .switchOn());
   // ------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'h2; hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   // Expected {oe, superspeed enable, usb3, usb2} for the bench's view of the state.
   function automatic logic [9:0] expPorts(input logic [2:0] dis, input logic [2:0] oc);
      logic [2:0] en, u2;
      logic s4;
      en = ~dis;
      u2 = en & ~oc;
      s4 = split & ss & en[1];
      return {dis, s4, split ? {u2[2], s4, 1'b0} : u2, u2};
   endfunction
   task automatic chkPorts(input logic [2:0] oc, input string m);
      @(negedge mclk);
      chk({port5PowerSensePinOe, port4PowerSensePinOe, port3PowerSensePinOe,
         port4SuperspeedPowerEnable, portUsb3Power, portUsb2Power},
         expPorts(cfgDis | hostPortDisable, oc), m);
   endtask
   task results;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #1000000;
      errors++;
      results;
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0; rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; hostPortDisable = 3'h0; ocReq = 3'h0;
      cfgDis = 3'h7; split = 1'b0; ss = 1'b0;
      void'($urandom(32'h1958));
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      chkPorts(3'h0, "reset pins");
      ahb(1'b0, `DPPC_CFG_OFFSET, 32'h0); chk(rd, 32'h7, "cfg reset");
      ahb(1'b0, `DPPC_IRQ_MASK_OFFSET, 32'h0); chk(rd, 32'h0, "mask reset");
      chk(hresp, 1'b0, "okay response");
      $display("test reset done");
      for (i = 0; i < 16; i++) begin
         cfgDis = i[2:0]; split = i[3]; ss = 1'($urandom);
         ahb(1'b1, `DPPC_CFG_OFFSET, {27'h0, ss, split, cfgDis});
         chkPorts(3'h0, "config ports");
      end
      $display("test config done");
      cfgDis = 3'h0; split = 1'b0;
      ahb(1'b1, `DPPC_CFG_OFFSET, 32'h0);
      for (i = 0; i < 6; i++) begin
         @(posedge mclk) hostPortDisable <= 3'($urandom);
         chkPorts(3'h0, "host disable");
         ahb(1'b0, `DPPC_STATUS_OFFSET, 32'h0);
         // The cast keeps the inversion at three bits, so upper bits compare as zero.
         chk(rd[2:0], 3'(~hostPortDisable), "status enables");
      end
      $display("test host done");
      ahb(1'b1, `DPPC_IRQ_MASK_OFFSET, 32'h1);
      // Port 3 is re-enabled with the fault already present to probe blanking.
      @(posedge mclk) begin hostPortDisable <= 3'h1; ocReq <= 3'h1; end
      @(posedge mclk) hostPortDisable <= 3'h0;
      repeat (`DPPC_OC_BLANK_CYCLES - 10) @(posedge mclk);
      chkPorts(3'h0, "blanking");
      repeat (20) @(posedge mclk);
      chkPorts(3'h1, "overcurrent power");
      chk(irq, 1'b1, "irq raised");
      chk(portOvercurrent, 3'h1, "oc level");
      ahb(1'b0, `DPPC_STATUS_OFFSET, 32'h0); chk(rd[5:3], 3'h1, "oc status");
      ocReq <= 3'h0;
      repeat (5) @(posedge mclk);
      ahb(1'b1, `DPPC_IRQ_STAT_OFFSET, 32'h1);
      @(negedge mclk) chk(irq, 1'b0, "irq cleared");
      @(posedge mclk) ocReq <= 3'h4;
      repeat (10) @(posedge mclk);
      chkPorts(3'h4, "port 5 overcurrent");
      chk(irq, 1'b0, "masked irq");
      ahb(1'b0, `DPPC_IRQ_STAT_OFFSET, 32'h0); chk(rd, 32'h4, "sticky stat");
      ocReq <= 3'h0;
      ahb(1'b1, `DPPC_IRQ_STAT_OFFSET, 32'h4);
      $display("test overcurrent done");
      ahb(1'b1, 8'h10, $urandom);
      ahb(1'b0, 8'h10, 32'h0); chk(rd, 32'h0, "unmapped read");
      ahb(1'b1, `DPPC_STATUS_OFFSET, 32'hFFFFFFFF);
      ahb(1'b0, `DPPC_CFG_OFFSET, 32'h0); chk(rd, 32'h0, "cfg kept");
      chkPorts(3'h0, "ports kept");
      $display("test map done");
      // A reset in mid-run must turn every port off again.
      @(posedge mclk) rstn <= 1'b0;
      cfgDis = 3'h7;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      chkPorts(3'h0, "mid-run reset pins");
      ahb(1'b0, `DPPC_CFG_OFFSET, 32'h0); chk(rd, 32'h7, "cfg after reset");
      $display("test reset again done");
      results;
   end
endmodule
bind dppc_top dppc_checker i_chk (.mclk, .rstn, .hostPortDisable, .portUsb2Power,
   .portUsb3Power, .portOvercurrent, .port4SuperspeedPowerEnable, .port3PowerSensePinIn,
   .port3PowerSensePinOut, .port3PowerSensePinOe, .port3PowerSensePinPu,
   .port4PowerSensePinOut, .port4PowerSensePinOe, .port4PowerSensePinPu,
   .port5PowerSensePinOut, .port5PowerSensePinOe, .port5PowerSensePinPu);
